// [pic_cpu_model.sv]
// CPU side model: accepts the non-maskable request when the bench allows it.
// Assumes pclk domain signals from the controller.
module pic_cpu_model (
   input  wire logic       pclk,        // System clock
   input  wire logic       presetn,     // Async reset, low
   input  wire logic       ack_on,      // Bench allows acceptance
   input  wire logic       int_request, // From controller
   input  wire logic [4:0] int_vector,  // From controller
   output logic            cpu_ack      // One-cycle acceptance
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ack_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_ack <= 1'b0;
         ack_d   <= 1'b0;
      end else begin
         // Holdoff keeps one acceptance per request
         cpu_ack <= ack_on && int_request && int_vector == 5'h03 && !cpu_ack && !ack_d;
         ack_d   <= cpu_ack;
      end
   end
endmodule // pic_cpu_model

// [pic_pkg.sv]
// Constants for the prioritized interrupt controller.
// Assumes an APB bus with 32-bit data; byte offsets are register indices x4.
package pic_pkg;
   localparam int          PIC_AW          = 18;
   localparam logic [15:0] PIC_IDX_EDGE1   = 16'hfff2;
   localparam logic [15:0] PIC_IDX_EDGE2   = 16'hfff3;
   localparam logic [15:0] PIC_IDX_EN1     = 16'hfff4;
   localparam logic [15:0] PIC_IDX_EN2     = 16'hfff5;
   localparam logic [15:0] PIC_IDX_EN3     = 16'hfff6;
   localparam logic [15:0] PIC_IDX_FLAG1   = 16'hfff7;
   localparam logic [15:0] PIC_IDX_FLAG2   = 16'hfff8;
   localparam logic [15:0] PIC_IDX_FLAG3   = 16'hfff9;
   localparam logic [7:0]  PIC_RST_EDGE1   = 8'h70;
   localparam logic [7:0]  PIC_RST_EDGE2   = 8'h00;
   localparam logic [7:0]  PIC_RST_EN1     = 8'h10;
   localparam logic [7:0]  PIC_RST_EN2     = 8'h00;
   localparam logic [7:0]  PIC_RST_EN3     = 8'h00;
   localparam logic [7:0]  PIC_RST_FLAG1   = 8'h10;
   localparam logic [7:0]  PIC_RST_FLAG2   = 8'h00;
   localparam logic [7:0]  PIC_RST_FLAG3   = 8'h00;
   localparam logic [7:0]  PIC_FIX_EDGE1   = 8'h70;
   localparam logic [7:0]  PIC_FIX_REG1    = 8'h10;
   localparam int          PIC_BIT_NMI_EDG = 7;
   localparam int          PIC_BIT_PIN7    = 7;
   localparam int          PIC_BIT_PIN6    = 6;
   localparam int          PIC_NPIN        = 13;
   localparam int          PIC_NSRC        = 18;
   localparam logic [4:0]  PIC_VEC_RESET   = 5'h00;
   localparam logic [4:0]  PIC_VEC_NMI     = 5'h03;
   // Vector of each maskable source, highest priority first
   localparam logic [4:0]  PIC_VEC_TAB [0:17] = '{
      5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c,
      5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h14, 5'h16, 5'h17};
endpackage

// [pic_top.sv]
// Prioritized interrupt controller: edge capture, flags, enables, vector pick.
// Assumes APB master on pclk; peripheral requests are pclk pulses (timer X/V levels).
//
// Added by the designer: the APB interface to the registers.
module pic_top (
   input  wire logic                 pclk,            // System clock
   input  wire logic                 presetn,         // Async reset, low
   input  wire logic                 psel,            // APB select
   input  wire logic                 penable,         // APB enable
   input  wire logic                 pwrite,          // APB write
   input  wire logic [17:0]          paddr,           // APB byte address
   input  wire logic [31:0]          pwdata,          // APB write data
   input  wire logic [3:0]           pstrb,           // APB byte strobes
   output logic      [31:0]          prdata,          // APB read data
   output logic                      pready,          // APB ready
   output logic                      pslverr,         // APB error
   input  wire logic                 nonmaskable_pin, // External pin
   input  wire logic [3:0]           irq_pin,         // External IRQ pins
   input  wire logic [7:0]           wakeup_pin,      // External INT pins
   input  wire logic                 timer_y_ovf,     // Pulse
   input  wire logic                 timer_a_ovf,     // Pulse
   input  wire logic                 timer_b1_ovf,    // Pulse
   input  wire logic                 timer_b2_ovf,    // Pulse
   input  wire logic                 timer_b3_ovf,    // Pulse
   input  wire logic                 timer_c_ovf,     // Pulse, over/underflow
   input  wire logic                 timer_e_ovf,     // Pulse
   input  wire logic [6:0]           timer_x_req,     // Levels
   input  wire logic [2:0]           timer_v_req,     // Levels
   input  wire logic                 serial_one_done, // Pulse
   input  wire logic                 serial_two_done, // Pulse
   input  wire logic                 serial_two_abort,// Pulse
   input  wire logic                 conv_end,        // Pulse
   input  wire logic                 direct_transfer, // Pulse
   input  wire logic                 cc_mask,         // CPU mask bit
   input  wire logic                 cpu_ack,         // Acceptance pulse
   output logic                      int_request,     // To CPU
   output logic      [4:0]           int_vector,      // Vector number
   output logic      [15:0]          int_vector_addr, // Vector word address
   output logic                      timer_y_edge_rise, // Timer Y input edge
   output logic                      timer_b_edge_rise  // Timer B input edge
);

   logic [7:0]  edge1_reg;
   logic [7:0]  edge2_reg;
   logic [7:0]  en1_reg;
   logic [7:0]  en2_reg;
   logic [7:0]  en3_reg;
   logic [7:0]  flag1_reg;
   logic [7:0]  flag2_reg;
   logic [7:0]  flag3_reg;
   logic        nmi_pend_reg;
   logic [12:0] sync1_reg;
   logic [12:0] sync2_reg;
   logic [12:0] sync3_reg;
   logic [12:0] level_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] prdata_reg;
   logic        req_reg;
   logic [4:0]  vec_reg;

   // Bus decode
   wire [15:0] idx      = paddr[17:2];
   wire        aligned  = (paddr[1:0] == 2'b00);
   wire        s_edge1  = aligned && (idx == pic_pkg::PIC_IDX_EDGE1);
   wire        s_edge2  = aligned && (idx == pic_pkg::PIC_IDX_EDGE2);
   wire        s_en1    = aligned && (idx == pic_pkg::PIC_IDX_EN1);
   wire        s_en2    = aligned && (idx == pic_pkg::PIC_IDX_EN2);
   wire        s_en3    = aligned && (idx == pic_pkg::PIC_IDX_EN3);
   wire        s_flag1  = aligned && (idx == pic_pkg::PIC_IDX_FLAG1);
   wire        s_flag2  = aligned && (idx == pic_pkg::PIC_IDX_FLAG2);
   wire        s_flag3  = aligned && (idx == pic_pkg::PIC_IDX_FLAG3);
   wire        hit      = s_edge1 | s_edge2 | s_en1 | s_en2 | s_en3 |
                          s_flag1 | s_flag2 | s_flag3;
   wire        access   = psel & penable;
   wire        wr_fire  = access & pready_reg & pwrite & pstrb[0] & hit;
   wire [7:0]  wd       = pwdata[7:0];

   wire [7:0] rd_byte =
      s_edge1 ? edge1_reg :
      s_edge2 ? edge2_reg :
      s_en1   ? en1_reg   :
      s_en2   ? en2_reg   :
      s_en3   ? en3_reg   :
      s_flag1 ? flag1_reg :
      s_flag2 ? flag2_reg :
      s_flag3 ? flag3_reg : 8'h00;

   // Pin order: [0] non-maskable, [4:1] IRQ3..0, [12:5] WAKEUP_PIN_7..0
   wire [12:0] pin_in   = {wakeup_pin, irq_pin, nonmaskable_pin};
   wire [12:0] pin_sel  = {edge2_reg, edge1_reg[3:0],
                           edge1_reg[pic_pkg::PIC_BIT_NMI_EDG]};
   wire [12:0] agree    = ~(sync2_reg ^ sync3_reg);
   wire [12:0] rise     = agree & sync3_reg & ~level_reg;
   wire [12:0] fall     = agree & ~sync3_reg & level_reg;
   wire [12:0] pin_evt  = (pin_sel & rise) | (~pin_sel & fall);

   // Flag set terms, hardware side
   wire [7:0] set1 = {timer_b1_ovf, timer_a_ovf, timer_y_ovf, 1'b0,
                      pin_evt[4:1]};
   wire [7:0] set2 = {direct_transfer,
                      conv_end,
                      serial_two_done | serial_two_abort,
                      serial_one_done,
                      timer_e_ovf,
                      timer_c_ovf,
                      timer_b3_ovf,
                      timer_b2_ovf};
   wire [7:0] set3 = pin_evt[12:5];

   // Per-register write strobes
   wire       we_edge1 = wr_fire & s_edge1;
   wire       we_edge2 = wr_fire & s_edge2;
   wire       we_en1   = wr_fire & s_en1;
   wire       we_en2   = wr_fire & s_en2;
   wire       we_en3   = wr_fire & s_en3;
   wire       we_flag1 = wr_fire & s_flag1;
   wire       we_flag2 = wr_fire & s_flag2;
   wire       we_flag3 = wr_fire & s_flag3;

   // Write of 1 keeps a flag, write of 0 clears it; set wins
   wire [7:0] keep1 = we_flag1 ? wd : 8'hff;
   wire [7:0] keep2 = we_flag2 ? wd : 8'hff;
   wire [7:0] keep3 = we_flag3 ? wd : 8'hff;
   wire [7:0] flag1_next = (flag1_reg & keep1) | set1 | pic_pkg::PIC_FIX_REG1;
   wire [7:0] flag2_next = (flag2_reg & keep2) | set2;
   wire [7:0] flag3_next = (flag3_reg & keep3) | set3;

   wire [7:0] edge1_next = we_edge1 ? (wd | pic_pkg::PIC_FIX_EDGE1)
                                    : edge1_reg;
   wire [7:0] edge2_next = we_edge2 ? wd : edge2_reg;
   wire [7:0] en1_next   = we_en1 ? (wd | pic_pkg::PIC_FIX_REG1)
                                  : en1_reg;
   wire [7:0] en2_next   = we_en2 ? wd : en2_reg;
   wire [7:0] en3_next   = we_en3 ? wd : en3_reg;

   // Candidates in priority order, lowest first
   wire x_any = |timer_x_req;
   wire v_any = |timer_v_req;
   wire [17:0] cand = {
      flag2_reg[7] & en2_reg[7],              // Direct transfer, 23
      flag2_reg[6] & en2_reg[6],              // Conversion end, 22
      flag2_reg[5] & en2_reg[5],              // Serial two, 20
      flag2_reg[4] & en2_reg[4],              // Serial one, 19
      v_any,                                  // Timer V, 17
      x_any,                                  // Timer X, 16
      flag2_reg[3] & en2_reg[3],              // Timer E, 15
      flag2_reg[2] & en2_reg[2],              // Timer C, 14
      flag2_reg[1] & en2_reg[1],              // Timer B3, 13
      flag2_reg[0] & en2_reg[0],              // Timer B2, 12
      flag1_reg[7] & en1_reg[7],              // Timer B1, 11
      flag1_reg[6] & en1_reg[6],              // Timer A, 10
      flag1_reg[5] & en1_reg[5],              // Timer Y, 9
      |(flag3_reg & en3_reg),                 // INT pins, 8
      flag1_reg[3] & en1_reg[3],              // IRQ3, 7
      flag1_reg[2] & en1_reg[2],              // IRQ2, 6
      flag1_reg[1] & en1_reg[1],              // IRQ1, 5
      flag1_reg[0] & en1_reg[0]};             // IRQ0, 4

   function automatic logic [4:0] pick(input logic [17:0] req);
      logic [4:0] v;
      v = pic_pkg::PIC_VEC_RESET;
      for (int i = 17; i >= 0; i--) begin
         if (req[i]) begin
            v = pic_pkg::PIC_VEC_TAB[i];
         end
      end
      return v;
   endfunction

   wire        mask_ok   = ~cc_mask & (|cand);
   wire        nmi_clr   = cpu_ack & req_reg & (vec_reg == pic_pkg::PIC_VEC_NMI);
   wire        nmi_next  = pin_evt[0] | (nmi_pend_reg & ~nmi_clr);
   wire        req_next  = nmi_pend_reg | mask_ok;
   wire [4:0]  vec_next  = nmi_pend_reg ? pic_pkg::PIC_VEC_NMI : pick(cand);
   wire [4:0]  vec_out   = req_next ? vec_next : pic_pkg::PIC_VEC_RESET;

   // Next values of the settled level and of the bus answer
   wire [12:0] level_next   = (agree & sync3_reg) | (~agree & level_reg);
   wire        pready_next  = access & ~pready_reg;
   wire        pslverr_next = access & ~pready_reg & ~hit;
   wire        rd_capture   = access & ~pready_reg;
   wire [31:0] prdata_next  = {24'h000000, rd_byte};

   // Pin synchroniser, first stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 13'h0000;
      end else begin
         sync1_reg <= pin_in;
      end
   end

   // Pin synchroniser, second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync2_reg <= 13'h0000;
      end else begin
         sync2_reg <= sync1_reg;
      end
   end

   // Pin synchroniser, third stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync3_reg <= 13'h0000;
      end else begin
         sync3_reg <= sync2_reg;
      end
   end

   // Last agreed pin level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 13'h0000;
      end else begin
         level_reg <= level_next;
      end
   end

   // Edge select, non-maskable and IRQ pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge1_reg <= pic_pkg::PIC_RST_EDGE1;
      end else begin
         edge1_reg <= edge1_next;
      end
   end

   // Edge select, INT pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge2_reg <= pic_pkg::PIC_RST_EDGE2;
      end else begin
         edge2_reg <= edge2_next;
      end
   end

   // First enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en1_reg <= pic_pkg::PIC_RST_EN1;
      end else begin
         en1_reg <= en1_next;
      end
   end

   // Second enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en2_reg <= pic_pkg::PIC_RST_EN2;
      end else begin
         en2_reg <= en2_next;
      end
   end

   // Third enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en3_reg <= pic_pkg::PIC_RST_EN3;
      end else begin
         en3_reg <= en3_next;
      end
   end

   // First request flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag1_reg <= pic_pkg::PIC_RST_FLAG1;
      end else begin
         flag1_reg <= flag1_next;
      end
   end

   // Second request flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag2_reg <= pic_pkg::PIC_RST_FLAG2;
      end else begin
         flag2_reg <= flag2_next;
      end
   end

   // Third request flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag3_reg <= pic_pkg::PIC_RST_FLAG3;
      end else begin
         flag3_reg <= flag3_next;
      end
   end

   // Pending non-maskable event, held until accepted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_reg <= 1'b0;
      end else begin
         nmi_pend_reg <= nmi_next;
      end
   end

   // Request level to the CPU
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_reg <= 1'b0;
      end else begin
         req_reg <= req_next;
      end
   end

   // Vector number to the CPU
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_reg <= pic_pkg::PIC_VEC_RESET;
      end else begin
         vec_reg <= vec_out;
      end
   end

   // Ready after exactly one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= pready_next;
      end
   end

   // Error for unmapped or misaligned access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= pslverr_next;
      end
   end

   // Read data, captured on the same edge that raises ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_capture) begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata            = prdata_reg;
   assign pready            = pready_reg;
   assign pslverr           = pslverr_reg;
   assign int_request       = req_reg;
   assign int_vector        = vec_reg;
   assign int_vector_addr   = {10'h000, vec_reg, 1'b0};
   assign timer_y_edge_rise = edge2_reg[pic_pkg::PIC_BIT_PIN7];
   assign timer_b_edge_rise = edge2_reg[pic_pkg::PIC_BIT_PIN6];

endmodule // pic_top

// [pic_top_sva.sv]
// Checker for the interrupt controller, watching the top module's ports only.
// Assumes one clock domain; bound to the top module at the foot of this file.
module pic_top_chk (
   input wire logic        pclk,              // System clock
   input wire logic        presetn,           // Async reset, low
   input wire logic        pwrite,            // APB write
   input wire logic [17:0] paddr,             // APB byte address
   input wire logic [31:0] pwdata,            // APB write data
   input wire logic [3:0]  pstrb,             // APB byte strobes
   input wire logic [31:0] prdata,            // APB read data
   input wire logic        pready,            // APB ready
   input wire logic        pslverr,           // APB error
   input wire logic        cc_mask,           // CPU mask bit
   input wire logic [6:0]  timer_x_req,       // Timer X levels
   input wire logic [2:0]  timer_v_req,       // Timer V levels
   input wire logic        int_request,       // To CPU
   input wire logic [4:0]  int_vector,        // Vector number
   input wire logic [15:0] int_vector_addr,   // Vector word address
   input wire logic        timer_y_edge_rise, // Timer Y edge
   input wire logic        timer_b_edge_rise  // Timer B edge
);
   localparam logic [17:0] addr_edge1 = {pic_pkg::PIC_IDX_EDGE1, 2'b00};
   localparam logic [17:0] addr_edge2 = {pic_pkg::PIC_IDX_EDGE2, 2'b00};
   localparam logic [17:0] addr_en1   = {pic_pkg::PIC_IDX_EN1, 2'b00};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   vec_addr_a: assert property (
      int_vector_addr == {10'h000, int_vector, 1'b0}) else $error("vector address wrong");
   idle_zero_a: assert property (
      !int_request |-> int_vector == 5'h00) else $error("vector without request");
   vec_legal_a: assert property (
      int_request |-> int_vector inside {[5'h03:5'h11], 5'h13, 5'h14, 5'h16, 5'h17})
      else $error("vector outside the table");
   mask_block_a: assert property (
      int_request && $past(cc_mask) |-> int_vector == 5'h03) else $error("maskable under mask");
   timer_x_a: assert property (
      $past(presetn) && $past(|timer_x_req) && !$past(cc_mask) |-> int_request)
      else $error("timer x request not raised");
   timer_v_a: assert property (
      $past(presetn) && $past(|timer_v_req) && !$past(cc_mask) |-> int_request)
      else $error("timer v request not raised");
   unmapped_err_a: assert property (
      pready && (paddr[17:2] < 16'hfff2 || paddr[17:2] > 16'hfff9) |-> pslverr)
      else $error("unmapped access not refused");
   edge1_fixed_a: assert property (
      pready && !pwrite && paddr == addr_edge1 |-> prdata[6:4] == 3'b111)
      else $error("edge select fixed bits wrong");
   en1_fixed_a: assert property (
      pready && !pwrite && paddr == addr_en1 |-> prdata[4] == 1'b1)
      else $error("enable fixed bit wrong");
   edge2_steer_a: assert property (
      pready && pwrite && pstrb[0] && paddr == addr_edge2
      |=> {timer_y_edge_rise, timer_b_edge_rise} == $past(pwdata[7:6]))
      else $error("timer edge outputs not steered");
endmodule // pic_top_chk

bind pic_top pic_top_chk pic_top_chk_inst (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cc_mask(cc_mask), .timer_x_req(timer_x_req), .timer_v_req(timer_v_req),
   .int_request(int_request), .int_vector(int_vector), .int_vector_addr(int_vector_addr),
   .timer_y_edge_rise(timer_y_edge_rise), .timer_b_edge_rise(timer_b_edge_rise));

// [tb_pic_top.sv]
// Testbench for the interrupt controller: APB register tasks and request scenarios.
// Assumes the CPU model beside the design and the checker bound to it.
module tb_pic_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, nmi_pin, cc_mask, ack_on, cpu_ack;
   logic ty, ta, tb1, tb2, tb3, tc, te, s1, s2, s2a, conv, dt;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, irq_pin;
   logic [7:0]  wk_pin, rd;
   logic [6:0]  tx;
   logic [2:0]  tv;
   logic        pready, pslverr, int_request, ty_rise, tb_rise, er;
   logic [4:0]  int_vector;
   logic [15:0] int_vector_addr;
   int          miscompares, num_checks;
   wire  [31:0] vec_seen = {11'h0, int_vector, int_vector_addr};
   pic_top pic_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nonmaskable_pin(nmi_pin), .irq_pin(irq_pin),
      .wakeup_pin(wk_pin), .timer_y_ovf(ty), .timer_a_ovf(ta), .timer_b1_ovf(tb1),
      .timer_b2_ovf(tb2), .timer_b3_ovf(tb3), .timer_c_ovf(tc), .timer_e_ovf(te),
      .timer_x_req(tx), .timer_v_req(tv), .serial_one_done(s1), .serial_two_done(s2),
      .serial_two_abort(s2a), .conv_end(conv), .direct_transfer(dt), .cc_mask(cc_mask),
      .cpu_ack(cpu_ack), .int_request(int_request), .int_vector(int_vector),
      .int_vector_addr(int_vector_addr), .timer_y_edge_rise(ty_rise), .timer_b_edge_rise(tb_rise));
   pic_cpu_model pic_cpu_model_inst (.pclk(pclk), .presetn(presetn), .ack_on(ack_on),
      .int_request(int_request), .int_vector(int_vector), .cpu_ack(cpu_ack));
   always #10 pclk = ~pclk;
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask
   function automatic logic [31:0] vexp(input logic [4:0] v);
      return {11'h0, v, 10'h0, v, 1'b0};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         tally_and_finish();
      end else begin
         rd = prdata[7:0];
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp, input string nm);
      apb(1'b0, idx, 8'h00);
      chk(nm, {24'h0, rd}, {24'h0, exp});
   endtask
   task automatic t_reset();
      logic [7:0] ex [8];
      ex = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) rd_chk(16'hfff2 + 16'(i), ex[i], "reset value");
      $display("test reset done");
   endtask
   task automatic t_regs();
      wr(16'hfff2, 8'h00);
      rd_chk(16'hfff2, 8'h70, "edge1 fixed bits");
      wr(16'hfff4, 8'h00);
      rd_chk(16'hfff4, 8'h10, "enable1 fixed bit");
      wr(16'hfff3, 8'hc0);
      rd_chk(16'hfff3, 8'hc0, "edge2 read back");
      chk("timer edges", {30'h0, ty_rise, tb_rise}, 32'h3);
      wr(16'hfff3, 8'h00);
      apb(1'b0, 16'hfffa, 8'h00);
      chk("unmapped error", {31'h0, er}, 32'h1);
      $display("test registers done");
   endtask
   task automatic t_pin();
      irq_pin[0] <= 1'b0;
      wk_pin[7] <= 1'b0;
      tick(6);
      chk("disabled request", {31'h0, int_request}, 32'h0);
      rd_chk(16'hfff7, 8'h11, "irq0 flag");
      wr(16'hfff4, 8'h01);
      wr(16'hfff6, 8'h80);
      tick(2);
      chk("irq0 over pin", vec_seen, vexp(5'h04));
      wr(16'hfff7, 8'hff);
      rd_chk(16'hfff7, 8'h11, "write one keeps");
      wr(16'hfff7, 8'h00);
      tick(2);
      chk("pin vector", vec_seen, vexp(5'h08));
      wr(16'hfff8 + 16'h1, 8'h00);
      tick(2);
      chk("request drops", {31'h0, int_request}, 32'h0);
      irq_pin[0] <= 1'b1;
      wk_pin[7] <= 1'b1;
      wr(16'hfff4, 8'h00);
      wr(16'hfff6, 8'h00);
      $display("test pins done");
   endtask
   task automatic t_prio();
      logic [4:0] v [11];
      int         b [11];
      v = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h13, 5'h14, 5'h16, 5'h17};
      b = '{5, 6, 7, 0, 1, 2, 3, 4, 5, 6, 7};
      wr(16'hfff4, 8'he0);
      wr(16'hfff5, 8'hff);
      {ty, ta, tb1, tb2, tb3, tc, te, s1, s2a, conv, dt} <= '1;
      tick(1);
      {ty, ta, tb1, tb2, tb3, tc, te, s1, s2a, conv, dt} <= '0;
      tick(3);
      for (int i = 0; i < 11; i++) begin
         chk("priority vector", vec_seen, vexp(v[i]));
         wr(i < 3 ? 16'hfff7 : 16'hfff8, ~(8'h01 << b[i]));
         tick(2);
      end
      chk("all served", {31'h0, int_request}, 32'h0);
      wr(16'hfff4, 8'h00);
      wr(16'hfff5, 8'h00);
      tx <= 7'h40;
      tick(3);
      chk("timer x shared", vec_seen, vexp(5'h10));
      tx <= 7'h00;
      tv <= 3'h4;
      tick(3);
      chk("timer v shared", vec_seen, vexp(5'h11));
      tv <= 3'h0;
      tick(3);
      $display("test priority done");
   endtask
   task automatic t_mask();
      cc_mask <= 1'b1;
      wr(16'hfff4, 8'h01);
      irq_pin[0] <= 1'b0;
      tick(6);
      chk("masked request", {31'h0, int_request}, 32'h0);
      rd_chk(16'hfff7, 8'h11, "flag under mask");
      nmi_pin <= 1'b0;
      tick(6);
      chk("nonmaskable", vec_seen, vexp(5'h03));
      ack_on <= 1'b1;
      tick(4);
      chk("nonmaskable taken", {31'h0, int_request}, 32'h0);
      ack_on <= 1'b0;
      wr(16'hfff2, 8'h80);
      nmi_pin <= 1'b1;
      tick(6);
      chk("nonmaskable rising", vec_seen, vexp(5'h03));
      ack_on <= 1'b1;
      cc_mask <= 1'b0;
      tick(4);
      chk("irq0 after unmask", vec_seen, vexp(5'h04));
      $display("test mask done");
   endtask
   initial begin
      miscompares = 0;
      num_checks = 0;
      {pclk, presetn, psel, penable, pwrite, cc_mask, ack_on, paddr, pwdata} = '0;
      {ty, ta, tb1, tb2, tb3, tc, te, s1, s2, s2a, conv, dt, tx, tv} = '0;
      {nmi_pin, irq_pin, wk_pin, pstrb} = '1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      tick(3);
      t_reset();
      t_regs();
      t_pin();
      t_prio();
      t_mask();
      tally_and_finish();
   end
endmodule // tb_pic_top
